// ==== dv/safety_controller_model.sv ====
// Model of the external safety controller that drives both safety pins.
`timescale 1ns/10ps

module safety_controller_model #(
    parameter int PULSE_MAX_CYC = 39000
) (
    // Clock.
    input  wire logic mclk,
    // Contact and test pulse demands.
    input  wire logic close_a,
    input  wire logic close_b,
    input  wire logic pulse_a,
    input  wire logic pulse_b,
    // Safety pins.
    output logic      safety_input_a,
    output logic      safety_input_b
);

    ////////////////////////////////////////////////////////////////////////////////
    int cnt_a;
    int cnt_b;

    // Counts how long each test pulse has lasted so far.
    always_ff @(posedge mclk) begin
        cnt_a <= pulse_a ? cnt_a + 1 : 0;
        cnt_b <= pulse_b ? cnt_b + 1 : 0;
    end

    // A test pulse is cut short before it reaches 2 ms, whatever the demand says.
    assign safety_input_a = close_a & ~(pulse_a & (cnt_a < PULSE_MAX_CYC));
    assign safety_input_b = close_b & ~(pulse_b & (cnt_b < PULSE_MAX_CYC));

endmodule

// ==== dv/test_safe_torque_off_monitor.sv ====
// Self-checking bench for the dual-channel torque cutoff monitor.
`timescale 1ns/10ps

module test_safe_torque_off_monitor;

    ////////////////////////////////////////////////////////////////////////////////
    logic   mclk, rst, start_cmd, drive_running;
    logic   close_a, close_b, pulse_a, pulse_b, bad;
    logic   safety_input_a, safety_input_b;
    logic   run_enable, safety_status_output, trip_annunciate, history_write, fault_latched;
    logic   [1:0] sel;
    int     errors, n_compared, w;
    integer seed;

    // Design and the safety controller in front of it.
    safe_torque_off_monitor dut (.mclk(mclk), .rst(rst), .safety_input_a(safety_input_a),
        .safety_input_b(safety_input_b), .start_cmd(start_cmd),
        .drive_running(drive_running), .run_enable(run_enable),
        .safety_status_output(safety_status_output), .trip_annunciate(trip_annunciate),
        .history_write(history_write), .fault_latched(fault_latched));
    safety_controller_model ctrl (.mclk(mclk), .close_a(close_a), .close_b(close_b),
        .pulse_a(pulse_a), .pulse_b(pulse_b), .safety_input_a(safety_input_a),
        .safety_input_b(safety_input_b));

    // Clock at 20 MHz.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counts one comparison and reports a mismatch.
    task automatic check(input string name, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Moves n edges on, landing just after the last one.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask

    // Waits a bounded time for the drive to be enabled.
    task automatic wait_run;
        for (int i = 0; i < 20 && run_enable !== 1'b1; i++) cyc(1);
        if (run_enable !== 1'b1) begin
            errors++;
            report_and_stop();
        end
    endtask

    // Status is ON only with both contacts open.
    function automatic logic exp_status(input logic a, input logic b);
        return !a && !b;
    endfunction

    // Drive may run only with both contacts closed.
    function automatic logic exp_run(input logic a, input logic b);
        return a && b;
    endfunction

    // One start request, then the one-cycle history pulse.
    task automatic start_pulse(input logic exp_trip);
        start_cmd = 1'b1;
        cyc(1);
        start_cmd = 1'b0;
        check("history_write", history_write, exp_trip);
        check("trip_annunciate", trip_annunciate, exp_trip);
        cyc(1);
        check("history_write end", history_write, 1'b0);
    endtask

    // Watches that the running drive is never disturbed.
    task automatic watch(input int n);
        repeat (n) begin
            cyc(1);
            bad |= (run_enable !== 1'b1) | (trip_annunciate !== 1'b0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        seed = 32'h53ba3641;
        errors = 0;
        n_compared = 0;
        {rst, start_cmd, drive_running} = 3'h4;
        {close_a, close_b, pulse_a, pulse_b} = 4'h0;
        repeat (6) @(posedge mclk);
        #5 rst = 1'b0;
        cyc(3);
        check("status safe", safety_status_output, exp_status(close_a, close_b));
        check("run safe", run_enable, exp_run(close_a, close_b));
        start_pulse(1'b1);
        close_a = 1'b1;
        cyc(20);
        check("status single", safety_status_output, exp_status(close_a, close_b));
        check("run single", run_enable, exp_run(close_a, close_b));
        start_pulse(1'b1);
        cyc(10000);
        check("fault short mismatch", fault_latched, 1'b0);
        close_b = 1'b1;
        wait_run();
        check("status enabled", safety_status_output, exp_status(close_a, close_b));
        check("trip enabled", trip_annunciate, 1'b0);
        drive_running = 1'b1;
        start_pulse(1'b0);
        bad = 1'b0;
        for (int k = 0; k < 5; k++) begin
            w = (k == 4) ? 39000 : 1 + ($unsigned($random(seed)) % 8000);
            sel = (k == 3) ? 2'h3 : 2'(($random(seed) & 1) + 1);
            {pulse_b, pulse_a} = sel;
            watch(w);
            {pulse_b, pulse_a} = 2'h0;
            watch(300);
        end
        check("pulses ignored", bad, 1'b0);
        rst = 1'b1;
        cyc(2);
        check("run in reset", run_enable, 1'b0);
        check("fault in reset", fault_latched, 1'b0);
        rst = 1'b0;
        wait_run();
        check("run after reset", run_enable, 1'b1);
        report_and_stop();
    end

endmodule

// ==== rtl/safe_torque_off_monitor.sv ====
// Dual-channel torque cutoff monitor with mismatch fault latch.
//
// How it works
// RQ1 - A mismatch between the two qualified channels held past 3.0 s is always detected.
// RQ2 - With both channels low and no fault the drive is tripped, starting is blocked and the status is ON.
// RQ3 - With exactly one channel low the drive is tripped and starting blocked before any fault.
// RQ4 - When the mismatch timer expires the fault latches without any further input change.
// RQ5 - In the fault state the latch holds whatever the inputs do, the drive stays tripped, status OFF.
// RQ6 - Only the power-on reset clears the fault latch; no input clears it.
// RQ7 - Low pulses shorter than 2 ms on either channel are filtered out and never trip the drive.
// RQ8 - A channel counts as low only after staying low for the 6 ms qualification time.
// RQ9 - External equipment keeps its channel test pulses below 2 ms.
// RQ10 - A start attempted while either channel is low raises the trip annunciation at once.
// RQ11 - A channel going low while running raises the trip annunciation at once.
// RQ12 - A detected fault raises the trip annunciation at once.
// RQ13 - A trip at start or while running writes a history entry pulse.
// RQ14 - Torque cutoff becoming active while not running writes no history entry.
// RQ15 - Both channels high and no fault lets the drive run, with status OFF.
// RQ16 - A mismatch shorter than 1.6 s never latches a fault.
// RQ17 - Inputs are synchronised and all timing uses counters derived from the clock rate.
`timescale 1ns/10ps
`include "torque_cutoff_params.svh"

module safe_torque_off_monitor (
    // Clock and power-on reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Safety input pins.
    input  wire logic safety_input_a,
    input  wire logic safety_input_b,
    // Drive control.
    input  wire logic start_cmd,
    input  wire logic drive_running,
    // Outputs.
    output logic      run_enable,
    output logic      safety_status_output,
    output logic      trip_annunciate,
    output logic      history_write,
    output logic      fault_latched
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and low qualification filters, one per channel.

    logic [1:0] pin_in;
    logic [1:0] chan_high;
    assign pin_in = {safety_input_b, safety_input_a};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            logic [2:0]               sync_r;
            logic [`TC_QUAL_W-1:0]    cnt_r;
            logic [`TC_QUAL_W-1:0]    cnt_nxt;
            logic                     high_r;
            logic                     high_nxt;
            logic                     agree;
            logic                     level;

            // Stage 2 and 3 agree before the level counts.
            assign agree = (sync_r[1] == sync_r[2]);
            assign level = sync_r[2];

            // Highs are accepted at once; lows only after the full qualification time.
            always_comb begin
                cnt_nxt  = cnt_r;
                high_nxt = high_r;
                if (agree && level) begin
                    cnt_nxt  = '0;
                    high_nxt = 1'b1;
                end else if (agree && !level) begin
                    if (cnt_r >= `TC_QUAL_W'(`TC_QUAL_CYC - 1)) begin // RQ8
                        high_nxt = 1'b0; // RQ7
                    end else begin
                        cnt_nxt = cnt_r + `TC_QUAL_W'(1); // RQ17
                    end
                end
            end

            // Registers; pins start as low so the drive starts tripped.
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    sync_r <= 3'h0;
                    cnt_r  <= '0;
                    high_r <= 1'b0;
                end else begin
                    sync_r <= {sync_r[1:0], pin_in[g]}; // RQ17
                    cnt_r  <= cnt_nxt;
                    high_r <= high_nxt;
                end
            end

            assign chan_high[g] = high_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Monitor state machine and mismatch timer.

    torque_cutoff_pkg::mon_state_e state_r;
    torque_cutoff_pkg::mon_state_e state_nxt;
    logic [`TC_MISM_W-1:0]         mism_r;
    logic [`TC_MISM_W-1:0]         mism_nxt;
    logic                          mism_done;

    assign mism_done = (mism_r >= `TC_MISM_W'(`TC_MISMATCH_CYC - 1)); // RQ16

    // Next state from the qualified channels; the fault state has no exit.
    always_comb begin
        state_nxt = state_r;
        mism_nxt  = '0;
        unique case (state_r)
            torque_cutoff_pkg::ST_SAFE, torque_cutoff_pkg::ST_ENABLED: begin
                if (chan_high == 2'b11) begin
                    state_nxt = torque_cutoff_pkg::ST_ENABLED; // RQ15
                end else if (chan_high == 2'b00) begin
                    state_nxt = torque_cutoff_pkg::ST_SAFE; // RQ2
                end else begin
                    state_nxt = torque_cutoff_pkg::ST_SINGLE; // RQ3
                end
            end
            torque_cutoff_pkg::ST_SINGLE: begin
                if (chan_high == 2'b11) begin
                    state_nxt = torque_cutoff_pkg::ST_ENABLED;
                end else if (chan_high == 2'b00) begin
                    state_nxt = torque_cutoff_pkg::ST_SAFE;
                end else if (mism_done) begin
                    state_nxt = torque_cutoff_pkg::ST_FAULT; // RQ1 RQ4
                end else begin
                    mism_nxt = mism_r + `TC_MISM_W'(1); // RQ17
                end
            end
            torque_cutoff_pkg::ST_FAULT: begin
                state_nxt = torque_cutoff_pkg::ST_FAULT; // RQ5
            end
        endcase
    end

    // Only the power-on reset leaves the fault state.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= torque_cutoff_pkg::ST_SAFE; // RQ6
            mism_r  <= '0;
        end else begin
            state_r <= state_nxt;
            mism_r  <= mism_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, trip annunciation and history entry.

    logic run_r;
    logic run_nxt;
    logic stat_r;
    logic stat_nxt;
    logic flt_r;
    logic flt_nxt;
    logic trip_r;
    logic trip_nxt;
    logic hist_r;
    logic hist_nxt;
    logic cut_active;
    logic cut_active_d_r;

    assign cut_active = (state_nxt != torque_cutoff_pkg::ST_ENABLED);

    // Trip is sticky until the channels are healthy again; history pulses once.
    always_comb begin
        run_nxt  = (state_nxt == torque_cutoff_pkg::ST_ENABLED); // RQ15
        stat_nxt = (state_nxt == torque_cutoff_pkg::ST_SAFE); // RQ2 RQ5
        flt_nxt  = (state_nxt == torque_cutoff_pkg::ST_FAULT);
        trip_nxt = trip_r && cut_active;
        hist_nxt = 1'b0;
        if (cut_active && start_cmd) begin
            trip_nxt = 1'b1; // RQ10
            hist_nxt = 1'b1; // RQ13
        end
        if (cut_active && !cut_active_d_r && drive_running) begin
            trip_nxt = 1'b1; // RQ11
            hist_nxt = 1'b1; // RQ13 RQ14
        end
        if (flt_nxt) begin
            trip_nxt = 1'b1; // RQ12
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_r          <= 1'b0;
            stat_r         <= 1'b0;
            flt_r          <= 1'b0;
            trip_r         <= 1'b0;
            hist_r         <= 1'b0;
            cut_active_d_r <= 1'b1;
        end else begin
            run_r          <= run_nxt;
            stat_r         <= stat_nxt;
            flt_r          <= flt_nxt;
            trip_r         <= trip_nxt;
            hist_r         <= hist_nxt;
            cut_active_d_r <= cut_active;
        end
    end

    assign run_enable           = run_r;
    assign safety_status_output = stat_r;
    assign fault_latched        = flt_r;
    assign trip_annunciate      = trip_r;
    assign history_write        = hist_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_fault;
        state_r == torque_cutoff_pkg::ST_FAULT;
    endsequence

    fault_sticks_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
        s_fault |=> s_fault)
        else $error("Fault state was left.");
    fault_status_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
        s_fault |=> !safety_status_output && !run_enable && fault_latched)
        else $error("Fault outputs wrong.");
    single_blocks_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
        (chan_high == 2'b01 || chan_high == 2'b10) |=> !run_enable)
        else $error("Drive enabled with one channel low.");
    both_low_a: assert property (@(posedge mclk) disable iff (rst) // RQ2
        (chan_high == 2'b00 && state_r != torque_cutoff_pkg::ST_FAULT) |=>
        safety_status_output && !run_enable)
        else $error("Safe state outputs wrong.");
    short_no_fault_a: assert property (@(posedge mclk) disable iff (rst) // RQ16
        (state_r == torque_cutoff_pkg::ST_SINGLE && mism_r < `TC_MISM_W'(`TC_MISM_MIN_CYC))
        |=> state_r != torque_cutoff_pkg::ST_FAULT)
        else $error("Fault latched too early.");
    mism_fault_a: assert property (@(posedge mclk) disable iff (rst) // RQ4
        (state_r == torque_cutoff_pkg::ST_SINGLE && mism_done &&
         (chan_high == 2'b01 || chan_high == 2'b10)) |=> s_fault)
        else $error("Fault not latched at mismatch expiry.");
    start_trip_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
        (start_cmd && cut_active) |=> trip_annunciate && history_write)
        else $error("Start while cut off not annunciated.");
    idle_no_hist_a: assert property (@(posedge mclk) disable iff (rst) // RQ14
        (!start_cmd && !drive_running) |=> !history_write)
        else $error("History written while idle.");
    enable_ok_a: assert property (@(posedge mclk) disable iff (rst) // RQ15
        (chan_high == 2'b11 && state_r != torque_cutoff_pkg::ST_FAULT) |=>
        run_enable && !safety_status_output)
        else $error("Drive not enabled with both channels high.");
    run_drop_trip_a: assert property (@(posedge mclk) disable iff (rst) // RQ11
        (state_r == torque_cutoff_pkg::ST_ENABLED && chan_high != 2'b11 && drive_running)
        |=> trip_annunciate && history_write)
        else $error("Channel loss while running not annunciated.");
    fault_trip_a: assert property (@(posedge mclk) disable iff (rst) // RQ12
        s_fault |=> trip_annunciate)
        else $error("Fault not annunciated.");

endmodule

// ==== rtl/torque_cutoff_params.svh ====
// Timing constants for the dual-channel torque cutoff monitor.
`ifndef TORQUE_CUTOFF_PARAMS_SVH
`define TORQUE_CUTOFF_PARAMS_SVH

// Clock rate in Hz.
`define TC_CLK_HZ          20000000
// Low qualification time in microseconds (typical reaction time).
`define TC_QUAL_US         6000
// Qualification time in cycles; clock truncated to whole MHz, above the 2 ms pulse width.
`define TC_QUAL_CYC        ((`TC_QUAL_US * (`TC_CLK_HZ / 1000000)))
// Mismatch time before latching, in milliseconds; between 1.6 s and 3.0 s.
`define TC_MISMATCH_MS     2300
// Mismatch time in cycles.
`define TC_MISMATCH_CYC    ((`TC_MISMATCH_MS * (`TC_CLK_HZ / 1000)))
// Shortest mismatch that may ever latch a fault, in milliseconds.
`define TC_MISM_MIN_MS     1600
// Shortest latching mismatch in cycles.
`define TC_MISM_MIN_CYC    ((`TC_MISM_MIN_MS * (`TC_CLK_HZ / 1000)))
// Counter widths.
`define TC_QUAL_W          17
`define TC_MISM_W          26

`endif

// ==== rtl/torque_cutoff_pkg.sv ====
// Types shared by the torque cutoff monitor.
package torque_cutoff_pkg;

    // Monitor state: safe, enabled, one channel low, latched fault.
    typedef enum logic [1:0] {
        ST_SAFE    = 2'b00,
        ST_ENABLED = 2'b01,
        ST_SINGLE  = 2'b10,
        ST_FAULT   = 2'b11
    } mon_state_e;

endpackage
